// ### common/return_address_stack_cfg.svh
// constants of the return address stack: offsets, fields, reset values
`ifndef RETURN_ADDRESS_STACK_CFG_SVH
`define RETURN_ADDRESS_STACK_CFG_SVH

// ****************************************
// geometry
// ****************************************
`define RAS_PC_WIDTH        21
`define RAS_PTR_WIDTH       5
`define RAS_DEPTH           31
`define RAS_DEPTH_PTR       5'h1f
`define RAS_OVERFLOW_STEP   21'h000002
`define RAS_ADDR_WIDTH      4
`define RAS_DATA_WIDTH      8

// ****************************************
// register offsets
// ****************************************
`define RAS_ADDR_POINTER    4'h0
`define RAS_ADDR_TOP_LOW    4'h1
`define RAS_ADDR_TOP_HIGH   4'h2
`define RAS_ADDR_TOP_UPPER  4'h3
`define RAS_ADDR_IRQ_STATUS 4'h4
`define RAS_ADDR_IRQ_CLEAR  4'h5
`define RAS_ADDR_IRQ_ENABLE 4'h6
`define RAS_ADDR_CONFIG     4'h7
`define RAS_ADDR_LAST_OP    4'h8

// ****************************************
// fields and reset values
// ****************************************
`define RAS_BIT_FULL        7
`define RAS_BIT_UNDERFLOW   6
`define RAS_IRQ_WIDTH       3
`define RAS_IRQ_FULL        0
`define RAS_IRQ_UNDERFLOW   1
`define RAS_IRQ_OVF_RESET   2
`define RAS_CFG_OVF_RESET   0
`define RAS_CFG_RESET       1'b1
`define RAS_IRQ_EN_RESET    3'h0
`define RAS_LAST_POP_BIT    7

`endif

// ### common/return_address_stack_pkg.sv
// types of the return address stack
`include "return_address_stack_cfg.svh"

package return_address_stack_pkg;

	// ****************************************
	// operation kinds
	// ****************************************
	typedef enum logic [1:0] {
		CALL_OP,
		RELATIVE_SUBROUTINE_JUMP_OP,
		INTERRUPT_ACK_OP
	} push_kind_t;

	typedef enum logic [1:0] {
		RETURN_OP,
		EXIT_WITH_LITERAL_OP,
		EXIT_FROM_INTERRUPT_OP
	} pop_kind_t;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic                     valid;
		push_kind_t               kind;
		logic [`RAS_PC_WIDTH-1:0] pc;
	} push_req_t;

	typedef struct packed {
		logic      valid;
		pop_kind_t kind;
	} pop_req_t;

	typedef struct packed {
		logic                       wrStrobe;
		logic                       rdStrobe;
		logic [`RAS_ADDR_WIDTH-1:0] addr;
		logic [`RAS_DATA_WIDTH-1:0] wrData;
	} bus_req_t;

	typedef struct packed {
		logic                     valid;
		logic                     underflow;
		logic [`RAS_PC_WIDTH-1:0] pc;
	} pop_resp_t;

	typedef struct packed {
		logic [`RAS_DEPTH-1:0][`RAS_PC_WIDTH-1:0] entries;
		logic [`RAS_PTR_WIDTH-1:0]                pointer;
		logic                                     fullFlag;
		logic                                     underflowFlag;
		logic [`RAS_IRQ_WIDTH-1:0]                irqStatus;
		logic [`RAS_IRQ_WIDTH-1:0]                irqEnable;
		logic                                     overflowResetEnable;
		logic                                     lastWasPop;
		logic [1:0]                               lastKind;
		pop_resp_t                                popResp;
		logic                                     deviceResetReq;
		logic                                     irq;
		logic [`RAS_DATA_WIDTH-1:0]               rdData;
	} stack_state_t;

endpackage

// ### src/return_address_stack.sv
// return address stack of the core with pointer, top-of-stack and status registers
//
// Functional notes
// [RQ1] 31 entries of 21 bits, 5-bit pointer
// [RQ2] push pc on calls and interrupt acknowledge
// [RQ3] pop top entry on all three returns
// [RQ4] pc latch registers untouched by calls, returns
// [RQ5] pointer zero after every reset, no entry
// [RQ6] push: increment pointer, then write entry
// [RQ7] pop: read entry, then decrement pointer
// [RQ8] three top bytes access selected entry
// [RQ9] software reads and writes the pointer
// [RQ10] full after 31 pushes; software, power-on clear
// [RQ11] overflow reset: store pc plus two, reset
// [RQ12] no overflow reset: pointer stays 31, no overwrite
// [RQ13] pop at zero: pc zero, underflow flag
// [RQ14] underflow sticks until software or power-on
// [RQ15] underflow is no reset; registers kept
// [RQ16] storage apart from program and data space
// [RQ17] software masks interrupts during top access
// [RQ18] pointer write visible next cycle; a push, or a pop above zero, in the same cycle sets the pointer instead
`include "return_address_stack_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module return_address_stack
	import return_address_stack_pkg::*;
#(
	parameter int PC_WIDTH = `RAS_PC_WIDTH,
	parameter int DEPTH    = `RAS_DEPTH
) (
	input  wire logic                       ref_clk,
	input  wire logic                       reset_n,
	input  wire logic                       powerOnReset,
	input  wire push_req_t                  pushReq,
	input  wire pop_req_t                   popReq,
	input  wire bus_req_t                   busReq,
	output var  pop_resp_t                  popResp,
	output logic                            deviceResetReq,
	output logic                            irq,
	output logic [`RAS_DATA_WIDTH-1:0]      rdData,
	output logic [`RAS_PTR_WIDTH-1:0]       stackPointer,
	output logic                            stackFull,
	output logic                            stackUnderflow
);

	// ****************************************
	// elaboration check
	// ****************************************
	// the struct layout is fixed by the header; other sizes cannot be served
	generate
		if (PC_WIDTH != `RAS_PC_WIDTH || DEPTH != `RAS_DEPTH) begin : gBadSize
			$error("return_address_stack: PC_WIDTH and DEPTH must match the header");
		end
	endgenerate

	// ****************************************
	// helpers
	// ****************************************
	stack_state_t state_reg;
	stack_state_t state_next;

	// pointer 1..31 maps onto entry 0..30; pointer zero owns no entry
	function automatic logic [`RAS_PTR_WIDTH-1:0] entryIndex(input logic [`RAS_PTR_WIDTH-1:0] ptr);
		entryIndex = ptr - 5'h01;
	endfunction

	function automatic logic [`RAS_PC_WIDTH-1:0] entryAt(
		input logic [`RAS_DEPTH-1:0][`RAS_PC_WIDTH-1:0] mem,
		input logic [`RAS_PTR_WIDTH-1:0]                ptr
	);
		if (ptr == 5'h00) begin
			entryAt = '0;
		end else begin
			entryAt = mem[entryIndex(ptr)];
		end
	endfunction

	logic [`RAS_PC_WIDTH-1:0]  topEntry;
	logic [`RAS_PTR_WIDTH-1:0] bumpedPtr;
	logic [`RAS_IRQ_WIDTH-1:0] irqEvents;

	assign topEntry  = entryAt(state_reg.entries, state_reg.pointer); // see [RQ8]
	assign bumpedPtr = state_reg.pointer + 5'h01;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		state_next                   = state_reg;
		state_next.popResp.valid     = 1'b0;
		state_next.popResp.underflow = 1'b0;
		state_next.deviceResetReq    = 1'b0;
		state_next.rdData            = '0;
		irqEvents                    = '0;

		// software side; storage only reachable here and from the core ports
		if (busReq.wrStrobe) begin // see [RQ16]
			case (busReq.addr)
				`RAS_ADDR_POINTER: begin
					state_next.pointer = busReq.wrData[`RAS_PTR_WIDTH-1:0]; // see [RQ9] [RQ18]
					if (!busReq.wrData[`RAS_BIT_FULL]) begin
						state_next.fullFlag = 1'b0; // see [RQ10]
					end
					if (!busReq.wrData[`RAS_BIT_UNDERFLOW]) begin
						state_next.underflowFlag = 1'b0; // see [RQ14]
					end
				end
				`RAS_ADDR_TOP_LOW: begin
					if (state_reg.pointer != 5'h00) begin
						state_next.entries[entryIndex(state_reg.pointer)][7:0] = busReq.wrData; // see [RQ8]
					end
				end
				`RAS_ADDR_TOP_HIGH: begin
					if (state_reg.pointer != 5'h00) begin
						state_next.entries[entryIndex(state_reg.pointer)][15:8] = busReq.wrData; // see [RQ8]
					end
				end
				`RAS_ADDR_TOP_UPPER: begin
					if (state_reg.pointer != 5'h00) begin
						state_next.entries[entryIndex(state_reg.pointer)][20:16] = busReq.wrData[4:0]; // see [RQ8]
					end
				end
				`RAS_ADDR_IRQ_CLEAR: begin
					state_next.irqStatus = state_reg.irqStatus & ~busReq.wrData[`RAS_IRQ_WIDTH-1:0];
				end
				`RAS_ADDR_IRQ_ENABLE: begin
					state_next.irqEnable = busReq.wrData[`RAS_IRQ_WIDTH-1:0];
				end
				`RAS_ADDR_CONFIG: begin
					state_next.overflowResetEnable = busReq.wrData[`RAS_CFG_OVF_RESET];
				end
				default: begin
				end
			endcase
		end

		// core side: only the pc is returned, the latch registers live elsewhere
		if (pushReq.valid) begin // see [RQ2] [RQ4]
			state_next.lastWasPop = 1'b0;
			state_next.lastKind   = pushReq.kind;
			if (state_reg.pointer == `RAS_DEPTH_PTR) begin
				state_next.pointer = state_reg.pointer; // see [RQ12]
			end else if (bumpedPtr == `RAS_DEPTH_PTR) begin
				irqEvents[`RAS_IRQ_FULL] = 1'b1; // see [RQ10]
				if (state_reg.overflowResetEnable) begin
					state_next.entries[entryIndex(bumpedPtr)] = pushReq.pc + `RAS_OVERFLOW_STEP; // see [RQ11]
					state_next.pointer                        = 5'h00;
					state_next.deviceResetReq                 = 1'b1;
					irqEvents[`RAS_IRQ_OVF_RESET]             = 1'b1;
				end else begin
					state_next.entries[entryIndex(bumpedPtr)] = pushReq.pc; // see [RQ12]
					state_next.pointer                        = bumpedPtr;
				end
			end else begin
				state_next.pointer                        = bumpedPtr; // see [RQ6] [RQ1]
				state_next.entries[entryIndex(bumpedPtr)] = pushReq.pc;
			end
		end else if (popReq.valid) begin // see [RQ3]
			state_next.lastWasPop    = 1'b1;
			state_next.lastKind      = popReq.kind;
			state_next.popResp.valid = 1'b1;
			if (state_reg.pointer == 5'h00) begin
				state_next.popResp.pc        = '0; // see [RQ13] [RQ15]
				state_next.popResp.underflow = 1'b1;
				irqEvents[`RAS_IRQ_UNDERFLOW] = 1'b1;
			end else begin
				state_next.popResp.pc = topEntry; // see [RQ7]
				state_next.pointer    = state_reg.pointer - 5'h01;
			end
		end

		// hardware set wins over a software clear in the same cycle
		if (irqEvents[`RAS_IRQ_FULL]) begin
			state_next.fullFlag = 1'b1; // see [RQ10]
		end
		if (irqEvents[`RAS_IRQ_UNDERFLOW]) begin
			state_next.underflowFlag = 1'b1; // see [RQ14]
		end
		state_next.irqStatus = state_next.irqStatus | irqEvents;

		// read data from the state before this cycle's writes
		if (busReq.rdStrobe) begin
			case (busReq.addr)
				`RAS_ADDR_POINTER: begin
					state_next.rdData = {state_reg.fullFlag, state_reg.underflowFlag, 1'b0, state_reg.pointer}; // see [RQ9]
				end
				`RAS_ADDR_TOP_LOW: begin
					state_next.rdData = topEntry[7:0]; // see [RQ8]
				end
				`RAS_ADDR_TOP_HIGH: begin
					state_next.rdData = topEntry[15:8];
				end
				`RAS_ADDR_TOP_UPPER: begin
					state_next.rdData = {3'h0, topEntry[20:16]};
				end
				`RAS_ADDR_IRQ_STATUS: begin
					state_next.rdData = {5'h00, state_reg.irqStatus};
				end
				`RAS_ADDR_IRQ_ENABLE: begin
					state_next.rdData = {5'h00, state_reg.irqEnable};
				end
				`RAS_ADDR_CONFIG: begin
					state_next.rdData = {7'h00, state_reg.overflowResetEnable};
				end
				`RAS_ADDR_LAST_OP: begin
					state_next.rdData = {state_reg.lastWasPop, 5'h00, state_reg.lastKind};
				end
				default: begin
					state_next.rdData = 8'h00;
				end
			endcase
		end

		state_next.irq = |(state_next.irqStatus & state_next.irqEnable);

		// any reset empties the stack; flags and storage only fall on power-on
		if (!reset_n) begin
			state_next.pointer        = 5'h00; // see [RQ5]
			state_next.popResp        = '0;
			state_next.deviceResetReq = 1'b0;
			state_next.rdData         = '0;
			state_next.irqStatus      = '0;
			state_next.irqEnable      = `RAS_IRQ_EN_RESET;
			state_next.irq            = 1'b0;
			state_next.lastWasPop     = 1'b0;
			state_next.lastKind       = 2'h0;
			if (powerOnReset) begin
				state_next.entries             = '0;
				state_next.fullFlag            = 1'b0; // see [RQ10] [RQ14]
				state_next.underflowFlag       = 1'b0;
				state_next.overflowResetEnable = `RAS_CFG_RESET;
			end
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge ref_clk) begin
		state_reg <= state_next;
	end

	assign popResp        = state_reg.popResp;
	assign deviceResetReq = state_reg.deviceResetReq;
	assign irq            = state_reg.irq;
	assign rdData         = state_reg.rdData;
	assign stackPointer   = state_reg.pointer;
	assign stackFull      = state_reg.fullFlag;
	assign stackUnderflow = state_reg.underflowFlag;

endmodule

`default_nettype wire

// ### bench/core_sequencer_model.sv
// core sequencer model: issues pushes and pops, collects answers
`timescale 1ns/1ps
`default_nettype none
module core_sequencer_model
	import return_address_stack_pkg::*;
(
	input  wire logic      ref_clk,
	input  wire pop_resp_t popResp,
	output var  push_req_t pushReq,
	output var  pop_req_t  popReq
);
	// ****
	// requests
	// ****
	initial begin
		pushReq = '0;
		popReq = '0;
	end
	// pc released to its inverse so a stale value never passes
	task automatic push(input push_kind_t kind, input logic [20:0] pc);
		@(posedge ref_clk);
		pushReq <= '{1'b1, kind, pc};
		@(posedge ref_clk);
		pushReq <= '{1'b0, kind, ~pc};
		#1;
	endtask
	task automatic pop(input pop_kind_t kind, output logic [20:0] pc, output logic uf);
		@(posedge ref_clk);
		popReq <= '{1'b1, kind};
		@(posedge ref_clk);
		popReq <= '{1'b0, kind};
		#1;
		pc = popResp.valid ? popResp.pc : 21'h1fffff;
		uf = popResp.underflow;
	endtask
endmodule
`default_nettype wire

// ### bench/return_address_stack_chk.sv
// port checker of the return address stack
`timescale 1ns/1ps
`default_nettype none
module return_address_stack_chk
	import return_address_stack_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       reset_n,
	input wire logic       powerOnReset,
	input wire push_req_t  pushReq,
	input wire pop_req_t   popReq,
	input wire bus_req_t   busReq,
	input wire pop_resp_t  popResp,
	input wire logic       deviceResetReq,
	input wire logic       irq,
	input wire logic [7:0] rdData,
	input wire logic [4:0] stackPointer,
	input wire logic       stackFull,
	input wire logic       stackUnderflow
);
	// ****
	// properties
	// ****
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire logic popOnly = popReq.valid && !pushReq.valid;
	wire logic ptrWr = busReq.wrStrobe && busReq.addr == 4'h0;
	sequence underflowAnswer;
		popResp.valid && popResp.underflow && popResp.pc == 21'h000000 && stackPointer == 5'h00 && stackUnderflow;
	endsequence
	sequence fullAnswer;
		stackFull && (stackPointer == 5'h00 && deviceResetReq || stackPointer == 5'h1f && !deviceResetReq);
	endsequence
	push_incr_a: assert property (pushReq.valid && stackPointer < 5'h1e |=> stackPointer == $past(stackPointer) + 5'h01)
		else $error("push did not advance pointer");
	pop_decr_a: assert property (popOnly && stackPointer != 5'h00 |=> popResp.valid && stackPointer == $past(stackPointer) - 5'h01)
		else $error("pop did not retreat pointer");
	pop_under_a: assert property (popOnly && stackPointer == 5'h00 |=> underflowAnswer)
		else $error("underflow pop answered wrongly");
	full_push_a: assert property (pushReq.valid && stackPointer == 5'h1e |=> fullAnswer)
		else $error("31st push mishandled");
	full_hold_a: assert property (pushReq.valid && stackPointer == 5'h1f && !busReq.wrStrobe |=> stackPointer == 5'h1f)
		else $error("pointer left 31 on push");
	ptr_write_a: assert property (ptrWr && !pushReq.valid && !popReq.valid |=> stackPointer == $past(busReq.wrData[4:0]))
		else $error("pointer write lost");
	under_sticky_a: assert property (stackUnderflow && !(ptrWr && !busReq.wrData[6]) |=> stackUnderflow)
		else $error("underflow flag dropped");
	read_idle_a: assert property (!busReq.rdStrobe |=> rdData == 8'h00)
		else $error("read data without read");
	resp_cause_a: assert property (popResp.valid |-> $past(popOnly))
		else $error("pop answer without pop");
	reset_pulse_a: assert property (deviceResetReq |=> !deviceResetReq)
		else $error("overflow reset longer than a cycle");
endmodule
bind return_address_stack return_address_stack_chk chk (.ref_clk, .reset_n, .powerOnReset, .pushReq, .popReq,
	.busReq, .popResp, .deviceResetReq, .irq, .rdData, .stackPointer, .stackFull, .stackUnderflow);
`default_nettype wire

// ### bench/test_return_address_stack.sv
// self-checking bench of the return address stack
`timescale 1ns/1ps
`default_nettype none
module test_return_address_stack
	import return_address_stack_pkg::*;
;
	logic        refClk;
	logic        resetN;
	logic        powerOn;
	push_req_t   pushReq;
	pop_req_t    popReq;
	bus_req_t    busReq;
	pop_resp_t   popResp;
	logic        deviceResetReq;
	logic        irq;
	logic [7:0]  rdData;
	logic [4:0]  stackPointer;
	logic        stackFull;
	logic        stackUnderflow;
	logic [20:0] pc;
	logic        uf;
	logic [7:0]  d;
	int          n_fail;
	int          comparisons;
	return_address_stack DUT (.ref_clk(refClk), .reset_n(resetN), .powerOnReset(powerOn), .pushReq(pushReq),
		.popReq(popReq), .busReq(busReq), .popResp(popResp), .deviceResetReq(deviceResetReq), .irq(irq),
		.rdData(rdData), .stackPointer(stackPointer), .stackFull(stackFull), .stackUnderflow(stackUnderflow));
	core_sequencer_model core (.ref_clk(refClk), .popResp(popResp), .pushReq(pushReq), .popReq(popReq));
	// ****
	// helpers
	// ****
	task automatic check(input logic [20:0] got, input logic [20:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge refClk);
		busReq <= '{1'b1, 1'b0, a, v};
		@(posedge refClk);
		busReq <= '0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
		@(posedge refClk);
		busReq <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge refClk);
		busReq <= '0;
		#1;
		check(rdData, exp, what);
	endtask
	task automatic rst(input logic por);
		@(posedge refClk);
		resetN <= 1'b0;
		powerOn <= por;
		repeat (4) @(posedge refClk);
		resetN <= 1'b1;
		powerOn <= 1'b0;
		#1;
	endtask
	task automatic settle;
		repeat (2) @(posedge refClk);
		#1;
	endtask
	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	task automatic test_lifo;
		for (int i = 0; i < 3; i++) begin
			core.push(push_kind_t'(i), 21'h1abcd0 + 21'(i));
			check(stackPointer, 21'(i + 1), "push pointer");
		end
		rd(4'h1, 8'hd2, "top low");
		rd(4'h3, 8'h1a, "top upper");
		wr(4'h6, 8'h02);
		rd(4'h6, 8'h02, "irq enable readback");
		for (int i = 2; i >= 0; i--) begin
			core.pop(pop_kind_t'(2 - i), pc, uf);
			check(pc, 21'h1abcd0 + 21'(i), "pop order");
		end
		core.pop(RETURN_OP, pc, uf);
		check({uf, pc}, 22'h200000, "underflow pop");
		settle;
		check(irq, 1'b1, "irq raised");
		rd(4'h7, 8'h01, "config kept");
		rd(4'h0, 8'h40, "underflow flag");
		wr(4'h6, 8'h00);
		settle;
		check(irq, 1'b0, "irq masked");
		wr(4'h5, 8'h02);
		wr(4'h6, 8'h02);
		wr(4'h0, 8'h00);
		settle;
		check({irq, stackUnderflow}, 2'b00, "flags cleared");
		$display("test lifo done");
	endtask
	// no interrupt push is made during top access
	task automatic test_software;
		core.push(CALL_OP, 21'h000011);
		core.push(CALL_OP, 21'h000022);
		wr(4'h0, 8'h01);
		check(stackPointer, 21'h1, "pointer write");
		rd(4'h1, 8'h11, "top after write");
		wr(4'h1, 8'h5a);
		wr(4'h2, 8'ha5);
		wr(4'h3, 8'hfc);
		rd(4'h3, 8'h1c, "upper bits");
		core.pop(EXIT_WITH_LITERAL_OP, pc, uf);
		check(pc, 21'h1ca55a, "popped top");
		rd(4'h8, 8'h81, "last op pop kind");
		rd(4'hf, 8'h00, "unmapped");
		$display("test software done");
	endtask
	task automatic fill(input logic [20:0] last);
		for (int i = 0; i < 30; i++)
			core.push(INTERRUPT_ACK_OP, 21'(i));
		core.push(CALL_OP, last);
	endtask
	task automatic test_full;
		wr(4'h7, 8'h00);
		fill(21'h00001e);
		check({stackFull, stackPointer}, 6'h3f, "full hold");
		core.push(CALL_OP, 21'h1fffff);
		check(stackPointer, 21'h1f, "extra push");
		core.pop(EXIT_FROM_INTERRUPT_OP, pc, uf);
		check(pc, 21'h00001e, "no overwrite");
		wr(4'h0, 8'h00);
		wr(4'h7, 8'h01);
		fill(21'h000030);
		check({deviceResetReq, stackFull, stackPointer}, 7'h60, "overflow reset");
		wr(4'h0, 8'h9f);
		rd(4'h1, 8'h32, "pc plus two");
		rd(4'h4, 8'h05, "full and overflow status");
		rst(1'b0);
		check({stackFull, stackPointer}, 6'h20, "full kept");
		rst(1'b1);
		check({stackFull, stackPointer}, 6'h00, "power-on clear");
		$display("test full done");
	endtask
	// ****
	// sequence
	// ****
	initial begin
		refClk = 1'b0;
		forever #4 refClk = ~refClk;
	end
	initial begin
		#100000;
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_of_test;
	end
	initial begin
		resetN = 1'b0;
		powerOn = 1'b1;
		busReq = '0;
		n_fail = 0;
		comparisons = 0;
		rst(1'b1);
		rd(4'h0, 8'h00, "pointer at reset");
		test_lifo;
		test_software;
		test_full;
		end_of_test;
	end
endmodule
`default_nettype wire
